/* File: rwu_core_model.sv */
`default_nettype none
// core side: restarts on request, takes the vector at once or late
module rwu_core_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic kick,
	input  wire logic ack_en,
	input  wire logic slow,
	input  wire logic wdt_irq,
	output var  logic wdt_restart,
	output var  logic wdt_irq_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_r;
	// guard on the ack stops a second take of one request
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_r <= 4'h0;
			wdt_restart <= 1'b0;
			wdt_irq_ack <= 1'b0;
		end else begin
			wdt_restart <= kick;
			wait_r <= (wdt_irq && ack_en) ? wait_r + 4'h1 : 4'h0;
			wdt_irq_ack <= wdt_irq && ack_en && !wdt_irq_ack &&
				wait_r == (slow ? 4'hc : 4'h1);
		end
	end
endmodule
`default_nettype wire

/* File: rwu_map.vh */
`ifndef RWU_MAP_VH
`define RWU_MAP_VH

// register byte offsets
`define RWU_OFF_CTRL     8'h00
`define RWU_OFF_FLAGS    8'h04
`define RWU_OFF_STAT     8'h08

// control register fields
`define RWU_CTL_IF       7
`define RWU_CTL_IE       6
`define RWU_CTL_P3       5
`define RWU_CTL_CE       4
`define RWU_CTL_RE       3
`define RWU_CTL_PLO_HI   2
`define RWU_CTL_RESET    8'h00

// reset flag fields, written zero clears
`define RWU_FLG_POR      0
`define RWU_FLG_EXT      1
`define RWU_FLG_BOD      2
`define RWU_FLG_WDR      3
`define RWU_FLG_RESET    4'h1

// watchdog prescaler
`define RWU_WD_BASE      21'h00_0800
`define RWU_WD_PSEL_MAX  4'h9
`define RWU_CE_WINDOW    3'h4

// timing
`define RWU_CLK_NS       25
`define RWU_BOD_MIN_NS   2000
`define RWU_BOD_MIN_CYC  ((`RWU_BOD_MIN_NS + `RWU_CLK_NS - 1) / `RWU_CLK_NS)

// delay counter states, one-hot
`define RWU_ST_HOLD      3'h1
`define RWU_ST_COUNT     3'h2
`define RWU_ST_RUN       3'h4

`endif

/* File: rwu_sync.v */
`default_nettype none

// three-stage synchroniser; level follows once stages two and three agree
module rwu_sync #(
	parameter WIDTH = 4
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             clk_en,
	input  wire [WIDTH-1:0] reset_val,
	input  wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg s1_r;
			reg s2_r;
			reg s3_r;
			reg q_r;
			// stages hold pin xor idle level, so reset reads as idle
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
					q_r  <= 1'b0;
				end else if (clk_en) begin
					s1_r <= d[i] ^ reset_val[i];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r) begin
						q_r <= s3_r;
					end
				end
			end
			assign q[i] = q_r ^ reset_val[i];
		end
	endgenerate
endmodule

`default_nettype wire

/* File: rwu_top.v */
// Function
// - hold reset while power-on detect active; then delay; reassert at once
// - low external reset pin resets asynchronously, even without clock
// - on external pin release, run start-up delay before releasing reset
// - enabled brown-out asserts reset once it lasts the minimum duration; release after delay
// - brown-out shorter than minimum duration is ignored
// - watchdog reset is one-cycle pulse; delay starts at its end
// - reference on if brown-out enabled, bandgap select or converter on
// - watchdog counter advances on dedicated oscillator cycles
// - restart instruction clears watchdog counter before time-out
// - interrupt mode raises wake-capable interrupt on expiry
// - reset mode resets device on expiry
// - combined mode: first expiry interrupts, later expiry resets
// - always-on fuse forces reset enable one, interrupt enable zero
// - clear reset-enable or prescaler only in next write within four cycles
// - time-out selectable from about 16 ms to about 8 s
// - after watchdog reset, reset mode stays until flag then enable cleared
// - reset-enable reads and acts set while watchdog reset flag set
// - change-enable clears itself four cycles after set
// - time-out is 2048 shl code oscillator cycles; codes above nine reserved
// - combined mode vector clears interrupt enable and flag
//
// The APB register port and the address map were chosen for this implementation.
`default_nettype none
`include "rwu_map.vh"

module rwu_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        clk_en,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        por_active,
	input  wire        ext_reset_n,
	input  wire        brownout_detector,
	input  wire        brownout_enable,
	input  wire        watchdog_always_on_fuse,
	input  wire        comparator_bandgap_select,
	input  wire        adc_enable,
	input  wire        wdt_osc,
	input  wire        wdt_restart,
	input  wire        wdt_irq_ack,
	input  wire [15:0] startup_delay_period,
	output reg         sys_reset_n,
	output reg         wdt_irq,
	output reg         vref_enable
);
	// pins into the clock domain
	wire [3:0] pin_s;
	wire       osc_s;
	wire       por_s;
	wire       ext_n_s;
	wire       bod_s;

	// asynchronous path for the reset tree
	wire hard_rst_n;

	// registers
	reg        ce_r;
	reg  [2:0] ce_cnt_r;
	reg        re_r;
	reg        ie_r;
	reg        if_r;
	reg  [3:0] psel_r;
	reg  [3:0] flags_r;
	reg  [19:0] wd_cnt_r;
	reg        osc_d_r;
	reg        wd_pulse_r;
	reg  [7:0] bod_cnt_r;
	reg        bod_q_r;
	reg  [2:0] state_r;
	reg  [15:0] dly_cnt_r;

	// next values
	reg        ce_nxt;
	reg  [2:0] ce_cnt_nxt;
	reg        re_nxt;
	reg        ie_nxt;
	reg        if_nxt;
	reg  [3:0] psel_nxt;
	reg  [3:0] flags_nxt;
	reg  [19:0] wd_cnt_nxt;
	reg        wd_pulse_nxt;
	reg  [2:0] state_nxt;
	reg  [15:0] dly_cnt_nxt;

	wire        wr;
	wire        rd_edge;
	wire        osc_tick;
	wire        re_eff;
	wire        ie_eff;
	wire        wd_run;
	wire [3:0]  psel_eff;
	wire [20:0] wd_limit;
	wire [19:0] wd_last;
	wire        wd_expire;
	wire        any_src;
	wire [3:0]  w_psel;

	// ext pin idles high, so its synchroniser resets to high
	rwu_sync #(
		.WIDTH(4)
	) u_sync (
		.clk      (pclk),
		.rst_n    (presetn),
		.clk_en   (clk_en),
		.reset_val(4'h4),
		.d        ({brownout_detector, ext_reset_n, por_active, wdt_osc}),
		.q        (pin_s)
	);
	assign osc_s   = pin_s[0];
	assign por_s   = pin_s[1];
	assign ext_n_s = pin_s[2];
	assign bod_s   = pin_s[3];

	// pin and detector act on the reset tree with no clock
	assign hard_rst_n = presetn & ext_reset_n & ~por_active;

	// bus strobes; write lands at the edge where pready is sampled high
	assign wr      = psel & penable & pready & pwrite;
	assign rd_edge = psel & penable & ~pready;

	// watchdog oscillator edge, taken from the agreed level only
	assign osc_tick = osc_s & ~osc_d_r;

	// fuse overrides both stored enables; reset flag overrides the reset enable only
	assign re_eff = watchdog_always_on_fuse | re_r
		| flags_r[`RWU_FLG_WDR];
	assign ie_eff = ie_r & ~watchdog_always_on_fuse;
	assign wd_run = re_eff | ie_eff;

	// reserved prescaler codes fall back to the longest period
	assign psel_eff = (psel_r > `RWU_WD_PSEL_MAX) ? `RWU_WD_PSEL_MAX
		: psel_r;
	assign wd_limit = `RWU_WD_BASE << psel_eff;
	assign wd_last  = wd_limit[19:0] - 20'h0_0001;
	assign wd_expire = wd_run & osc_tick & (wd_cnt_r == wd_last);

	assign w_psel = {pwdata[`RWU_CTL_P3], pwdata[`RWU_CTL_PLO_HI:0]};

	// control register and protected change sequence
	always @* begin
		ce_nxt     = ce_r;
		ce_cnt_nxt = ce_cnt_r;
		re_nxt     = re_r;
		ie_nxt     = ie_r;
		psel_nxt   = psel_r;
		// change window closes on its own
		if (ce_r) begin
			ce_cnt_nxt = ce_cnt_r - 3'h1;
			if (ce_cnt_r == 3'h1) begin
				ce_nxt = 1'b0;
			end
		end
		if (wr && paddr == `RWU_OFF_CTRL) begin
			ie_nxt = pwdata[`RWU_CTL_IE];
			if (pwdata[`RWU_CTL_CE] && pwdata[`RWU_CTL_RE]) begin
				ce_nxt     = 1'b1;
				ce_cnt_nxt = `RWU_CE_WINDOW;
				re_nxt     = 1'b1;
			end else if (ce_r && !pwdata[`RWU_CTL_CE]) begin
				re_nxt   = pwdata[`RWU_CTL_RE];
				psel_nxt = w_psel;
				ce_nxt   = 1'b0;
			end else begin
				// outside the window the enable may only be set
				re_nxt = re_r | pwdata[`RWU_CTL_RE];
			end
		end
		// combined-mode vector drops back to reset mode
		if (wdt_irq_ack && if_r && re_eff) begin
			ie_nxt = 1'b0;
		end
	end

	// watchdog counter, interrupt flag and reset pulse
	always @* begin
		wd_cnt_nxt   = wd_cnt_r;
		wd_pulse_nxt = 1'b0;
		if_nxt       = if_r;
		if (!wd_run || wdt_restart) begin
			wd_cnt_nxt = 20'h0_0000;
		end else if (osc_tick) begin
			wd_cnt_nxt = wd_expire ? 20'h0_0000 : wd_cnt_r + 20'h0_0001;
		end
		// clear by vector or by writing one; a new expiry wins below
		if (wdt_irq_ack) begin
			if_nxt = 1'b0;
		end
		if (wr && paddr == `RWU_OFF_CTRL && pwdata[`RWU_CTL_IF]) begin
			if_nxt = 1'b0;
		end
		if (wd_expire && !wdt_restart) begin
			if (ie_eff && !(re_eff && if_r)) begin
				if_nxt = 1'b1;
			end else if (re_eff) begin
				wd_pulse_nxt = 1'b1;
			end
		end
	end

	// reset flags; hardware set beats software clear
	always @* begin
		flags_nxt = flags_r;
		if (wr && paddr == `RWU_OFF_FLAGS) begin
			flags_nxt = flags_r & pwdata[3:0];
		end
		if (!ext_n_s) begin
			flags_nxt[`RWU_FLG_EXT] = 1'b1;
		end
		if (por_s) begin
			flags_nxt[`RWU_FLG_POR] = 1'b1;
		end
		if (bod_q_r) begin
			flags_nxt[`RWU_FLG_BOD] = 1'b1;
		end
		if (wd_pulse_r) begin
			flags_nxt[`RWU_FLG_WDR] = 1'b1;
		end
	end

	// any active source keeps the delay counter parked
	assign any_src = por_s | ~ext_n_s | bod_q_r | wd_pulse_r;

	// start-up delay sequencer
	always @* begin
		state_nxt   = state_r;
		dly_cnt_nxt = dly_cnt_r;
		case (state_r)
			`RWU_ST_HOLD: begin
				dly_cnt_nxt = 16'h0000;
				if (!any_src) begin
					state_nxt = `RWU_ST_COUNT;
				end
			end
			`RWU_ST_COUNT: begin
				if (any_src) begin
					state_nxt = `RWU_ST_HOLD;
				end else if (dly_cnt_r >= startup_delay_period) begin
					state_nxt = `RWU_ST_RUN;
				end else if (osc_tick) begin
					dly_cnt_nxt = dly_cnt_r + 16'h0001;
				end
			end
			`RWU_ST_RUN: begin
				if (any_src) begin
					state_nxt = `RWU_ST_HOLD;
				end
			end
			default: begin
				state_nxt = `RWU_ST_HOLD;
			end
		endcase
	end

	// reset tree flops; cleared by pin or detector with no clock
	always @(posedge pclk or negedge hard_rst_n) begin
		if (!hard_rst_n) begin
			state_r     <= `RWU_ST_HOLD;
			dly_cnt_r   <= 16'h0000;
			sys_reset_n <= 1'b0;
		end else if (clk_en) begin
			state_r     <= state_nxt;
			dly_cnt_r   <= dly_cnt_nxt;
			sys_reset_n <= (state_nxt == `RWU_ST_RUN);
		end
	end

	// brown-out qualifier; short dips never reach the sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bod_cnt_r <= 8'h00;
			bod_q_r   <= 1'b0;
		end else if (clk_en) begin
			if (!brownout_enable || !bod_s) begin
				bod_cnt_r <= 8'h00;
				bod_q_r   <= 1'b0;
			end else if (bod_cnt_r >= `RWU_BOD_MIN_CYC) begin
				bod_q_r   <= 1'b1;
			end else begin
				bod_cnt_r <= bod_cnt_r + 8'h01;
			end
		end
	end

	// watchdog and control state, kept across internal resets
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ce_r       <= 1'b0;
			ce_cnt_r   <= 3'h0;
			re_r       <= 1'b0;
			ie_r       <= 1'b0;
			if_r       <= 1'b0;
			psel_r     <= 4'h0;
			flags_r    <= `RWU_FLG_RESET;
			wd_cnt_r   <= 20'h0_0000;
			osc_d_r    <= 1'b0;
			wd_pulse_r <= 1'b0;
		end else if (clk_en) begin
			ce_r       <= ce_nxt;
			ce_cnt_r   <= ce_cnt_nxt;
			re_r       <= re_nxt;
			ie_r       <= ie_nxt;
			if_r       <= if_nxt;
			psel_r     <= psel_nxt;
			flags_r    <= flags_nxt;
			wd_cnt_r   <= wd_cnt_nxt;
			osc_d_r    <= osc_s;
			wd_pulse_r <= wd_pulse_nxt;
		end
	end

	// registered side outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_irq     <= 1'b0;
			vref_enable <= 1'b0;
		end else if (clk_en) begin
			wdt_irq     <= if_nxt & ie_nxt & ~watchdog_always_on_fuse;
			vref_enable <= brownout_enable | comparator_bandgap_select
				| adc_enable;
		end
	end

	// apb slave: one wait state, answer registered
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (clk_en) begin
			pready  <= rd_edge;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (rd_edge) begin
				case (paddr)
					`RWU_OFF_CTRL: begin
						prdata[`RWU_CTL_IF] <= if_r;
						prdata[`RWU_CTL_IE] <= ie_eff;
						prdata[`RWU_CTL_P3] <= psel_r[3];
						prdata[`RWU_CTL_CE] <= ce_r;
						prdata[`RWU_CTL_RE] <= re_eff;
						prdata[`RWU_CTL_PLO_HI:0] <= psel_r[2:0];
					end
					`RWU_OFF_FLAGS: begin
						prdata[3:0] <= flags_r;
					end
					`RWU_OFF_STAT: begin
						prdata[19:0] <= wd_cnt_r;
						prdata[22:20] <= state_r;
						prdata[23] <= bod_q_r;
					end
					default: begin
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule

`default_nettype wire

/* File: rwu_top_asserts.sv */
`default_nettype none
module rwu_top_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic por_active,
	input wire logic ext_reset_n,
	input wire logic brownout_enable,
	input wire logic comparator_bandgap_select,
	input wire logic adc_enable,
	input wire logic watchdog_always_on_fuse,
	input wire logic sys_reset_n,
	input wire logic wdt_irq,
	input wire logic vref_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	wire ref_req;
	// any of three users keeps the reference powered
	assign ref_req = brownout_enable | comparator_bandgap_select | adc_enable;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_bus_req;
		psel && penable && !pready && clk_en;
	endsequence
	sequence s_ref_held;
		(clk_en && ref_req) [*3];
	endsequence
	chk_por_hold: assert property (por_active |-> !sys_reset_n)
		else $error("reset open in power-on");
	chk_pin_hold: assert property (!ext_reset_n |-> !sys_reset_n)
		else $error("reset open, pin low");
	chk_pin_stretch: assert property (
		$rose(ext_reset_n) |-> !sys_reset_n [*4])
		else $error("no start-up delay");
	chk_ref_on: assert property (s_ref_held |-> vref_enable)
		else $error("reference off");
	chk_ref_off: assert property (
		(clk_en && !ref_req) [*3] |-> !vref_enable)
		else $error("reference on");
	chk_fuse_irq: assert property (
		watchdog_always_on_fuse [*4] |-> !wdt_irq)
		else $error("irq under fuse");
	chk_bus_answer: assert property (s_bus_req |=> pready)
		else $error("late bus answer");
	chk_bus_pulse: assert property (pready && clk_en |=> !pready)
		else $error("answer held");
endmodule
bind rwu_top rwu_top_asserts i_rwu_top_asserts (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
	.penable(penable), .pready(pready), .por_active(por_active),
	.ext_reset_n(ext_reset_n), .brownout_enable(brownout_enable),
	.comparator_bandgap_select(comparator_bandgap_select),
	.adc_enable(adc_enable),
	.watchdog_always_on_fuse(watchdog_always_on_fuse),
	.sys_reset_n(sys_reset_n), .wdt_irq(wdt_irq),
	.vref_enable(vref_enable));
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready;
	logic        por, ext_n, bo_det, bo_en, fuse, cbg, adc, osc, kick;
	logic        ack_en, slow, pslverr, er, sys_reset_n, wdt_irq;
	logic        vref_enable, rst_cmd, ack;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          errors, total_checks;
	typedef struct packed {
		logic [2:0]  en;
		logic [7:0]  a;
		logic [31:0] d;
		logic        e;
	} rwu_row_t;
	// reference users beside a read; unmapped places refused
	rwu_row_t rows [8] = '{
		'{3'h0, 8'h00, 32'h0000_0000, 1'b0},
		'{3'h1, 8'h04, 32'h0000_0001, 1'b0},
		'{3'h2, 8'h08, 32'h0040_0000, 1'b0},
		'{3'h3, 8'h0c, 32'h0000_0000, 1'b1},
		'{3'h4, 8'h10, 32'h0000_0000, 1'b1},
		'{3'h5, 8'h00, 32'h0000_0000, 1'b0},
		'{3'h6, 8'hfc, 32'h0000_0000, 1'b1},
		'{3'h7, 8'h04, 32'h0000_0001, 1'b0}};
	rwu_top i_rwu_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .por_active(por), .ext_reset_n(ext_n),
		.brownout_detector(bo_det), .brownout_enable(bo_en),
		.watchdog_always_on_fuse(fuse), .comparator_bandgap_select(cbg),
		.adc_enable(adc), .wdt_osc(osc), .wdt_restart(rst_cmd),
		.wdt_irq_ack(ack), .startup_delay_period(16'h0004),
		.sys_reset_n(sys_reset_n), .wdt_irq(wdt_irq),
		.vref_enable(vref_enable));
	rwu_core_model i_rwu_core_model (.pclk(pclk), .presetn(presetn),
		.kick(kick), .ack_en(ack_en), .slow(slow), .wdt_irq(wdt_irq),
		.wdt_restart(rst_cmd), .wdt_irq_ack(ack));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// slow oscillator so the synchroniser sees every edge
	initial begin
		osc = 1'b0;
		forever #55 osc = ~osc;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic final_report;
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// waits on reset (irq=0) or the interrupt (irq=1)
	task automatic wait_on(input logic irq, input logic v, input int lim);
		int n;
		n = 0;
		while ((irq ? wdt_irq : sys_reset_n) !== v && n < lim) begin
			@(posedge pclk);
			n++;
		end
		if (n >= lim) begin
			errors++;
			final_report;
		end
	endtask
	// one bus transfer; k keeps psel up for a back-to-back follower
	task automatic apb(input logic k, input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			final_report;
		end else begin
			rd = prdata;
			er = pslverr;
			penable <= 1'b0;
			if (!k) begin
				psel <= 1'b0;
				@(posedge pclk);
			end
		end
	endtask
	initial begin
		{errors, total_checks} = '0;
		{presetn, psel, penable, pwrite, por, bo_det, bo_en} = '0;
		{fuse, cbg, adc, kick, ack_en, slow, paddr, pwdata} = '0;
		{clk_en, ext_n} = 2'h3;
		tick(20);
		presetn <= 1'b1;
		wait_on(0, 1, 400);
		foreach (rows[i]) begin
			{bo_en, cbg, adc} <= rows[i].en;
			tick(3);
			chk(vref_enable, |rows[i].en);
			apb(0, 0, rows[i].a, 0);
			chk(rd, rows[i].d);
			chk(er, rows[i].e);
		end
		{bo_en, cbg, adc} <= 3'h0;
		$display("table done");
		// combined: interrupt first, then the vector drops back to reset mode
		ack_en <= 1'b1;
		apb(0, 1, 8'h00, 32'h0000_0048);
		wait_on(1, 1, 12000);
		chk(sys_reset_n, 1);
		wait_on(1, 0, 100);
		apb(0, 0, 8'h00, 0);
		chk(rd, 32'h0000_0008);
		wait_on(0, 0, 12000);
		wait_on(0, 1, 400);
		apb(0, 0, 8'h04, 0);
		chk(rd, 32'h0000_0009);
		// combined again, vector never taken: next expiry resets
		ack_en <= 1'b0;
		apb(0, 1, 8'h00, 32'h0000_0048);
		wait_on(1, 1, 12000);
		chk(sys_reset_n, 1);
		wait_on(0, 0, 12000);
		wait_on(0, 1, 400);
		apb(0, 1, 8'h00, 32'h0000_0088);
		apb(0, 0, 8'h00, 0);
		chk(rd, 32'h0000_0008);
		apb(1, 1, 8'h00, 32'h0000_0018);
		apb(0, 1, 8'h00, 32'h0000_0027);
		apb(0, 0, 8'h00, 0);
		chk(rd, 32'h0000_002f);
		apb(0, 1, 8'h04, 0);
		// second write after the window closed is ignored
		apb(0, 1, 8'h00, 32'h0000_0018);
		tick(4);
		apb(0, 1, 8'h00, 32'h0000_0000);
		apb(0, 0, 8'h00, 0);
		chk(rd, 32'h0000_002f);
		apb(1, 1, 8'h00, 32'h0000_0018);
		apb(0, 1, 8'h00, 32'h0000_0000);
		apb(0, 0, 8'h00, 0);
		chk(rd, 32'h0000_0000);
		$display("combined done");
		// restarts hold expiry off, then interrupt mode fires
		ack_en <= 1'b0;
		apb(0, 1, 8'h00, 32'h0000_0040);
		repeat (16) begin
			tick(600);
			kick <= 1'b1;
			tick(1);
			kick <= 1'b0;
		end
		chk(wdt_irq, 0);
		wait_on(1, 1, 12000);
		apb(0, 0, 8'h00, 0);
		chk(rd, 32'h0000_00c0);
		chk(sys_reset_n, 1);
		slow <= 1'b1;
		ack_en <= 1'b1;
		wait_on(1, 0, 100);
		apb(0, 0, 8'h00, 0);
		chk(rd, 32'h0000_0040);
		apb(0, 1, 8'h00, 0);
		fuse <= 1'b1;
		apb(0, 1, 8'h00, 32'h0000_0040);
		apb(0, 0, 8'h00, 0);
		chk(rd, 32'h0000_0008);
		fuse <= 1'b0;
		apb(0, 1, 8'h00, 0);
		$display("irq done");
		// a short dip is filtered, a long one resets
		bo_det <= 1'b1;
		tick(100);
		chk(sys_reset_n, 1);
		bo_en <= 1'b1;
		tick(40);
		bo_det <= 1'b0;
		tick(10);
		chk(sys_reset_n, 1);
		bo_det <= 1'b1;
		wait_on(0, 0, 120);
		bo_det <= 1'b0;
		wait_on(0, 1, 400);
		$display("brownout done");
		// pin reset with the clock held off, then power-on
		clk_en <= 1'b0;
		ext_n <= 1'b0;
		#2;
		chk(sys_reset_n, 0);
		tick(3);
		clk_en <= 1'b1;
		ext_n <= 1'b1;
		tick(10);
		chk(sys_reset_n, 0);
		wait_on(0, 1, 400);
		por <= 1'b1;
		#2;
		chk(sys_reset_n, 0);
		tick(2);
		por <= 1'b0;
		wait_on(0, 1, 400);
		$display("pin done");
		final_report;
	end
endmodule
`default_nettype wire
